// [include/drc_regs.vh]
// Purpose: Offsets, fields, reset values and timing for the compressor
// Assumes: Byte-wide register port with a page select
// Notes:   Gain arithmetic counts 2^24 units per dB
`ifndef DRC_REGS_VH
`define DRC_REGS_VH

// ----------------------------------------
// Pages and offsets
// ----------------------------------------
`define PAGE_CTRL        8'h00
`define PAGE_COEF        8'h09
`define OFS_FLAGS_LATCH  7'h2c
`define OFS_FLAGS_LIVE   7'h2e
`define OFS_VOLUME       7'h41
`define OFS_CONTROL      7'h44
`define OFS_HOLD         7'h45
`define OFS_RATES        7'h46
`define OFS_HP_N0        7'h0e
`define OFS_HP_N1        7'h10
`define OFS_HP_D1        7'h12
`define OFS_LP_N0        7'h14
`define OFS_LP_N1        7'h16
`define OFS_LP_D1        7'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_EN_HI       6
`define CTRL_EN_LO       5
`define CTRL_THR_HI      4
`define CTRL_THR_LO      2
`define CTRL_HYS_HI      1
`define CTRL_HYS_LO      0
`define HOLD_HI          6
`define HOLD_LO          3
`define RATE_ATK_HI      7
`define RATE_ATK_LO      4
`define RATE_DEC_HI      3
`define RATE_DEC_LO      0
`define FLAG_EXCEED      3
`define FLAG_ACTIVE      2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CONTROL      8'h0f
`define RST_HOLD         8'h00
`define RST_RATES        8'h00
`define RST_VOLUME       8'h00
`define RST_HP_N0        16'h7fab
`define RST_HP_N1        16'h8055
`define RST_HP_D1        16'h7f56
`define RST_LP_N0        16'h0011
`define RST_LP_N1        16'h0011
`define RST_LP_D1        16'h7fde

// ----------------------------------------
// Gain arithmetic and timing
// ----------------------------------------
`define ATK_MAX_STEP     32'h0400_0000
`define ATK_BASE_STEP    32'h0033_3333
`define DEC_BASE_STEP    32'h0000_6666
`define DEC_MIN_STEP     32'h0000_0008
`define CORR_MAX         32'h0000_0000
`define CORR_MIN         32'ha800_0000
`define HALF_DB_SHIFT    23
`define VOL_MAX          8'h30
`define VOL_MIN          8'h81
`define HOLD_UNIT        16'h0020
`define FIFO_DEPTH       16
`define SAMPLE_W         16

`endif

// [rtl/sample_fifo.v]
// Purpose: Sample buffer between volume stage and compressor
// Assumes: Single clock, depth a power of two
// Notes:   Valid/ready on both sides, no fall-through
`timescale 1ns/1ps

module sample_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// Clock and reset
	input  wire             sys_clk,
	input  wire             nrst,
	// Fill side
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	// Drain side
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	// Honest flags from the occupancy count
	assign in_ready  = (count != DEPTH);
	assign out_valid = (count != 0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage has no reset, only pointers and count do
	always @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and count
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push & ~pop) begin
				count <= count + 1'b1;
			end else if (pop & ~push) begin
				count <= count - 1'b1;
			end
		end
	end

endmodule

// [rtl/dynamic_range_compressor.v]
// Purpose: Playback dynamic range compressor with energy estimation
// Assumes: Samples arrive from the volume stage on sys_clk at 40 MHz
// Notes:   One sample per processing pass, four cycles per pass
`timescale 1ns/1ps
`include "drc_regs.vh"

// What this block does
// - Enable field off forces correction to zero; volume still applies
// - Measure level, cut on peaks, restore when quiet
// - High-pass first, then low-pass
// - First-order sections over two to fifteen
// - Sixteen-bit signed writable coefficients
// - Coefficient pairs at page nine 14-25
// - Coefficient resets give the stated cutoffs
// - High-pass out forwarded; low-pass magnitude measured
// - Applied gain combines volume and correction
// - Threshold minus three to minus 24 dBFS
// - Sticky flags cleared by host read
// - Live flags readable in register 46
// - Hysteresis zero to three dB
// - Activate above, release below hysteresis window
// - Hold delays start of decay
// - Attack lowers gain while above threshold
// - Attack from 4 dB to 1.2207e-5 dB
// - Decay raises gain at selected rate
// - Values 7F and B6 give recommended setup
// - Volume spans +24 to -63.5 dB
module dynamic_range_compressor (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        nrst,
	// Register port
	input  wire [7:0]  reg_page,
	input  wire [6:0]  reg_addr,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata,
	// Volume-stage samples in
	input  wire [15:0] vol_sample,
	input  wire        vol_valid,
	output wire        vol_ready,
	// High-pass samples out
	output reg  [15:0] hp_sample,
	output reg         hp_valid,
	input  wire        hp_ready,
	// Gain to the volume stage
	output reg  [7:0]  applied_gain,
	output reg         comp_active
);

	// ----------------------------------------
	// Processing states
	// ----------------------------------------
	localparam S_IDLE = 2'b00;
	localparam S_HPF  = 2'b01;
	localparam S_LPF  = 2'b10;
	localparam S_GAIN = 2'b11;

	reg  [7:0]  control;
	reg  [7:0]  hold_cfg;
	reg  [7:0]  rates;
	reg  [7:0]  volume;
	reg  [15:0] hp_n0, hp_n1, hp_d1;
	reg  [15:0] lp_n0, lp_n1, lp_d1;
	reg  [1:0]  flags_latched;
	reg  [1:0]  flags_live;
	reg  [1:0]  state;
	reg  [15:0] x_cur, x_prev;
	reg  [15:0] hp_prev;
	reg  [15:0] lp_prev;
	reg  [15:0] energy;
	reg  [31:0] corr;
	reg  [15:0] hold_cnt;
	reg  [31:0] next_corr;
	reg  [31:0] atk_step;
	reg  [31:0] dec_step;
	reg  [31:0] gain_sum;
	wire [15:0] fifo_data;
	wire        fifo_valid;
	wire        fifo_pop;
	wire        enabled;
	wire        ctrl_sel;
	wire        coef_sel;
	wire [4:0]  thr_idx;
	wire [4:0]  on_idx;
	wire [4:0]  off_idx;
	wire [1:0]  hyst;

	// ----------------------------------------
	// Sample buffer
	// ----------------------------------------
	// Pops only when the output slot is free, so a stalled
	// downstream fills the buffer and drops vol_ready
	assign fifo_pop = (state == S_IDLE) & (~hp_valid | hp_ready);

	sample_fifo #(
		.WIDTH (`SAMPLE_W),
		.DEPTH (`FIFO_DEPTH),
		.AW    (4)
	) u_fifo (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.in_data   (vol_sample),
		.in_valid  (vol_valid),
		.in_ready  (vol_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Shared first-order section, saturated to 16 bits
	function [15:0] iir;
		input [15:0] n0, n1, d1, x, x1, y1;
		reg signed [33:0] acc;
		begin
			acc = $signed(n0) * $signed(x)
				+ $signed(n1) * $signed(x1)
				+ $signed(d1) * $signed(y1);
			acc = acc >>> 15;
			if (acc > 34'sd32767) begin
				iir = 16'h7fff;
			end else if (acc < -34'sd32768) begin
				iir = 16'h8000;
			end else begin
				iir = acc[15:0];
			end
		end
	endfunction

	// Full-scale level for 0 to -27 dBFS in 1 dB steps
	function [15:0] db_level;
		input [4:0] k;
		begin
			case (k)
			5'd0:  db_level = 16'h7fff;
			5'd1:  db_level = 16'h7214;
			5'd2:  db_level = 16'h65ac;
			5'd3:  db_level = 16'h5a9d;
			5'd4:  db_level = 16'h50c3;
			5'd5:  db_level = 16'h47fa;
			5'd6:  db_level = 16'h4027;
			5'd7:  db_level = 16'h392d;
			5'd8:  db_level = 16'h32f5;
			5'd9:  db_level = 16'h2d6b;
			5'd10: db_level = 16'h287a;
			5'd11: db_level = 16'h2413;
			5'd12: db_level = 16'h2027;
			5'd13: db_level = 16'h1ca8;
			5'd14: db_level = 16'h198a;
			5'd15: db_level = 16'h16c3;
			5'd16: db_level = 16'h1449;
			5'd17: db_level = 16'h1215;
			5'd18: db_level = 16'h101d;
			5'd19: db_level = 16'h0e5d;
			5'd20: db_level = 16'h0ccd;
			5'd21: db_level = 16'h0b68;
			5'd22: db_level = 16'h0a2b;
			5'd23: db_level = 16'h0910;
			5'd24: db_level = 16'h0814;
			5'd25: db_level = 16'h0733;
			5'd26: db_level = 16'h066a;
			default: db_level = 16'h05b8;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Threshold and hysteresis decode
	// ----------------------------------------
	assign enabled  = |control[`CTRL_EN_HI:`CTRL_EN_LO];
	assign hyst     = control[`CTRL_HYS_HI:`CTRL_HYS_LO];
	// Code 0 is -3 dBFS, code 7 is -24 dBFS
	assign thr_idx  = {control[`CTRL_THR_HI:`CTRL_THR_LO], 1'b0}
		+ {2'b00, control[`CTRL_THR_HI:`CTRL_THR_LO]} + 5'd3;
	assign on_idx   = thr_idx - {3'b000, hyst};
	assign off_idx  = thr_idx + {3'b000, hyst};
	assign ctrl_sel = (reg_page == `PAGE_CTRL);
	assign coef_sel = (reg_page == `PAGE_COEF);

	// Rate tables in 2^-24 dB units
	always @* begin
		if (rates[`RATE_ATK_HI:`RATE_ATK_LO] == 4'd0) begin
			atk_step = `ATK_MAX_STEP;
		end else begin
			atk_step = `ATK_BASE_STEP
				>> (rates[`RATE_ATK_HI:`RATE_ATK_LO] - 4'd1);
		end
		dec_step = `DEC_BASE_STEP >> rates[`RATE_DEC_HI:`RATE_DEC_LO];
		if (dec_step < `DEC_MIN_STEP) begin
			dec_step = `DEC_MIN_STEP;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Coefficients update byte by byte; write both halves
	// between samples to avoid a torn value
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			control  <= `RST_CONTROL;
			hold_cfg <= `RST_HOLD;
			rates    <= `RST_RATES;
			volume   <= `RST_VOLUME;
			hp_n0    <= `RST_HP_N0;
			hp_n1    <= `RST_HP_N1;
			hp_d1    <= `RST_HP_D1;
			lp_n0    <= `RST_LP_N0;
			lp_n1    <= `RST_LP_N1;
			lp_d1    <= `RST_LP_D1;
		end else if (reg_wr) begin
			if (ctrl_sel && reg_addr == `OFS_CONTROL) begin
				control <= reg_wdata;
			end else if (ctrl_sel && reg_addr == `OFS_HOLD) begin
				hold_cfg <= reg_wdata;
			end else if (ctrl_sel && reg_addr == `OFS_RATES) begin
				rates <= reg_wdata;
			end else if (ctrl_sel && reg_addr == `OFS_VOLUME) begin
				volume <= reg_wdata;
			end else if (coef_sel && reg_addr[6:1] == `OFS_HP_N0 >> 1) begin
				if (reg_addr[0]) hp_n0[7:0] <= reg_wdata;
				else hp_n0[15:8] <= reg_wdata;
			end else if (coef_sel && reg_addr[6:1] == `OFS_HP_N1 >> 1) begin
				if (reg_addr[0]) hp_n1[7:0] <= reg_wdata;
				else hp_n1[15:8] <= reg_wdata;
			end else if (coef_sel && reg_addr[6:1] == `OFS_HP_D1 >> 1) begin
				if (reg_addr[0]) hp_d1[7:0] <= reg_wdata;
				else hp_d1[15:8] <= reg_wdata;
			end else if (coef_sel && reg_addr[6:1] == `OFS_LP_N0 >> 1) begin
				if (reg_addr[0]) lp_n0[7:0] <= reg_wdata;
				else lp_n0[15:8] <= reg_wdata;
			end else if (coef_sel && reg_addr[6:1] == `OFS_LP_N1 >> 1) begin
				if (reg_addr[0]) lp_n1[7:0] <= reg_wdata;
				else lp_n1[15:8] <= reg_wdata;
			end else if (coef_sel && reg_addr[6:1] == `OFS_LP_D1 >> 1) begin
				if (reg_addr[0]) lp_d1[7:0] <= reg_wdata;
				else lp_d1[15:8] <= reg_wdata;
			end
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	// Data appears one cycle after the read strobe
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (ctrl_sel && reg_addr == `OFS_FLAGS_LATCH) begin
				reg_rdata <= {4'h0, flags_latched, 2'b00};
			end else if (ctrl_sel && reg_addr == `OFS_FLAGS_LIVE) begin
				reg_rdata <= {4'h0, flags_live, 2'b00};
			end else if (ctrl_sel && reg_addr == `OFS_CONTROL) begin
				reg_rdata <= control;
			end else if (ctrl_sel && reg_addr == `OFS_HOLD) begin
				reg_rdata <= hold_cfg;
			end else if (ctrl_sel && reg_addr == `OFS_RATES) begin
				reg_rdata <= rates;
			end else if (ctrl_sel && reg_addr == `OFS_VOLUME) begin
				reg_rdata <= volume;
			end else if (coef_sel && reg_addr[6:1] == `OFS_HP_N0 >> 1) begin
				reg_rdata <= reg_addr[0] ? hp_n0[7:0] : hp_n0[15:8];
			end else if (coef_sel && reg_addr[6:1] == `OFS_HP_N1 >> 1) begin
				reg_rdata <= reg_addr[0] ? hp_n1[7:0] : hp_n1[15:8];
			end else if (coef_sel && reg_addr[6:1] == `OFS_HP_D1 >> 1) begin
				reg_rdata <= reg_addr[0] ? hp_d1[7:0] : hp_d1[15:8];
			end else if (coef_sel && reg_addr[6:1] == `OFS_LP_N0 >> 1) begin
				reg_rdata <= reg_addr[0] ? lp_n0[7:0] : lp_n0[15:8];
			end else if (coef_sel && reg_addr[6:1] == `OFS_LP_N1 >> 1) begin
				reg_rdata <= reg_addr[0] ? lp_n1[7:0] : lp_n1[15:8];
			end else if (coef_sel && reg_addr[6:1] == `OFS_LP_D1 >> 1) begin
				reg_rdata <= reg_addr[0] ? lp_d1[7:0] : lp_d1[15:8];
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// ----------------------------------------
	// Gain correction update
	// ----------------------------------------
	// Attack while active, hold after release, then decay
	always @* begin
		next_corr = corr;
		if (!enabled) begin
			next_corr = `CORR_MAX;
		end else if (comp_active && energy > db_level(thr_idx)) begin
			next_corr = corr - atk_step;
			if ($signed(next_corr) < $signed(`CORR_MIN)
				|| $signed(next_corr) > $signed(corr)) begin
				next_corr = `CORR_MIN;
			end
		end else if (!comp_active && hold_cnt == 16'h0000) begin
			next_corr = corr + dec_step;
			if ($signed(next_corr) > $signed(`CORR_MAX)) begin
				next_corr = `CORR_MAX;
			end
		end
		// Volume in half-dB units plus correction
		// Both terms signed, so the correction shift keeps its sign
		gain_sum = $signed({{24{volume[7]}}, volume})
			+ ($signed(next_corr) >>> `HALF_DB_SHIFT);
	end

	// ----------------------------------------
	// Sample processing
	// ----------------------------------------
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state        <= S_IDLE;
			x_cur        <= 16'h0000;
			x_prev       <= 16'h0000;
			hp_prev      <= 16'h0000;
			lp_prev      <= 16'h0000;
			energy       <= 16'h0000;
			hp_sample    <= 16'h0000;
			hp_valid     <= 1'b0;
			corr         <= `CORR_MAX;
			hold_cnt     <= 16'h0000;
			comp_active  <= 1'b0;
			applied_gain <= `RST_VOLUME;
			flags_live   <= 2'b00;
		end else begin
			if (hp_valid && hp_ready) begin
				hp_valid <= 1'b0;
			end
			case (state)
			S_IDLE: begin
				if (fifo_valid && fifo_pop) begin
					x_cur <= fifo_data;
					state <= S_HPF;
				end
			end
			S_HPF: begin
				// High-pass before low-pass
				hp_sample <= iir(hp_n0, hp_n1, hp_d1,
					x_cur, x_prev, hp_sample);
				x_prev    <= x_cur;
				state     <= S_LPF;
			end
			S_LPF: begin
				hp_valid <= 1'b1;
				lp_prev  <= iir(lp_n0, lp_n1, lp_d1,
					hp_sample, hp_prev, lp_prev);
				hp_prev  <= hp_sample;
				state    <= S_GAIN;
			end
			S_GAIN: begin
				// Magnitude of low-pass output, clipped at full scale
				if (lp_prev == 16'h8000) begin
					energy <= 16'h7fff;
				end else if (lp_prev[15]) begin
					energy <= 16'h0000 - lp_prev;
				end else begin
					energy <= lp_prev;
				end
				state <= S_IDLE;
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
			// Decision uses the estimate once per sample
			if (state == S_IDLE && fifo_valid && fifo_pop) begin
				corr <= next_corr;
				flags_live[1] <= enabled
					&& energy > db_level(thr_idx);
				// Live active bit follows the new hysteresis state
				flags_live[0] <= comp_active;
				if (!enabled) begin
					comp_active   <= 1'b0;
					flags_live[0] <= 1'b0;
					hold_cnt      <= 16'h0000;
				end else if (!comp_active
					&& energy > db_level(on_idx)) begin
					comp_active   <= 1'b1;
					flags_live[0] <= 1'b1;
				end else if (comp_active
					&& energy < db_level(off_idx)) begin
					comp_active   <= 1'b0;
					flags_live[0] <= 1'b0;
					hold_cnt    <= {12'h000,
						hold_cfg[`HOLD_HI:`HOLD_LO]}
						* `HOLD_UNIT;
				end else if (hold_cnt != 16'h0000) begin
					hold_cnt <= hold_cnt - 16'h0001;
				end
				// Clamp to the volume stage range
				if ($signed(gain_sum) > $signed({24'h000000, `VOL_MAX})) begin
					applied_gain <= `VOL_MAX;
				end else if ($signed(gain_sum)
					< $signed({24'hffffff, `VOL_MIN})) begin
					applied_gain <= `VOL_MIN;
				end else begin
					applied_gain <= gain_sum[7:0];
				end
			end
		end
	end

	// ----------------------------------------
	// Sticky flags
	// ----------------------------------------
	// A new event in the read cycle survives the clear
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			flags_latched <= 2'b00;
		end else begin
			flags_latched <= (flags_latched
				& ~{2{reg_rd && ctrl_sel
				&& reg_addr == `OFS_FLAGS_LATCH}})
				| flags_live;
		end
	end

endmodule

// [dv/drc_checker_assertions.sv]
// Purpose: Port-level temporal checks for the compressor
// Assumes: Sees only the top module ports, one clock domain
// Notes:   Shadows of control and volume writes track the host
`timescale 1ns/1ps
`include "drc_regs.vh"

module drc_checker (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        nrst,
	// Register port
	input wire logic [7:0]  reg_page,
	input wire logic [6:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	// Sample streams
	input wire logic [15:0] vol_sample,
	input wire logic        vol_valid,
	input wire logic        vol_ready,
	input wire logic [15:0] hp_sample,
	input wire logic        hp_valid,
	input wire logic        hp_ready,
	// Gain
	input wire logic [7:0]  applied_gain,
	input wire logic        comp_active
);
	logic never_en;
	logic vol_set;

	// Shadow of enable and volume writes; reset keeps the enable field at zero
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			never_en <= 1'b1;
			vol_set  <= 1'b0;
		end else if (reg_wr && reg_page == `PAGE_CTRL) begin
			if (reg_addr == `OFS_CONTROL && reg_wdata[6:5] != 2'b00)
				never_en <= 1'b0;
			if (reg_addr == `OFS_VOLUME)
				vol_set <= 1'b1;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_off_no_gain: assert property (never_en |-> !comp_active && (vol_set || applied_gain == 8'h00))
		else $error("gain moved while compressor disabled");
	a_gain_in_range: assert property ($signed(applied_gain) <= $signed(`VOL_MAX) && $signed(applied_gain) >= $signed(`VOL_MIN))
		else $error("applied gain outside volume span");
	a_hp_held: assert property (hp_valid && !hp_ready |=> hp_valid && $stable(hp_sample))
		else $error("filtered sample dropped while stalled");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	a_unmapped_zero: assert property (reg_rd && reg_page == 8'h05 |=> reg_rdata == 8'h00)
		else $error("unmapped page read not zero");
	a_live_flags: assert property (reg_rd && reg_page == `PAGE_CTRL && reg_addr == `OFS_FLAGS_LIVE
		|=> reg_rdata[2] == $past(comp_active) && reg_rdata[7:4] == 4'h0 && reg_rdata[1:0] == 2'b00)
		else $error("live flag read wrong");
	a_latch_fields: assert property (reg_rd && reg_page == `PAGE_CTRL && reg_addr == `OFS_FLAGS_LATCH
		|=> reg_rdata[7:4] == 4'h0 && reg_rdata[1:0] == 2'b00)
		else $error("latched flag read has stray bits");
	a_sample_gap: assert property ($fell(hp_valid) |-> !hp_valid [*2])
		else $error("filtered samples closer than one pass");

	// Main scenarios reached
	cover property ($rose(comp_active));
	cover property (hp_valid && hp_ready);
	cover property (!vol_ready);
endmodule

bind dynamic_range_compressor drc_checker i_chk (
	.sys_clk(sys_clk), .nrst(nrst), .reg_page(reg_page), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.vol_sample(vol_sample), .vol_valid(vol_valid), .vol_ready(vol_ready),
	.hp_sample(hp_sample), .hp_valid(hp_valid), .hp_ready(hp_ready),
	.applied_gain(applied_gain), .comp_active(comp_active)
);

// [dv/playback_partner.sv]
// Purpose: Volume-stage source and downstream sink around the compressor
// Assumes: Tasks are entered 2 ns after a rising edge
// Notes:   Stall input holds off the sink to back up the buffer
`timescale 1ns/1ps

module playback_partner (
	// Clock and control
	input wire logic         sys_clk,
	input wire logic         stall,
	// Source side
	output logic [15:0]      vol_sample,
	output logic             vol_valid,
	input wire logic         vol_ready,
	// Sink side
	input wire logic         hp_valid,
	output wire logic        hp_ready,
	output int               got
);
	initial begin
		vol_sample = 16'h0000;
		vol_valid  = 1'b0;
		got        = 0;
	end

	// Sink answers promptly or slowly as stall says
	assign hp_ready = !stall;

	always @(posedge sys_clk)
		if (hp_valid && hp_ready)
			got <= got + 1;

	// ----------------------------------------
	// Source tasks
	// ----------------------------------------
	// Hold the sample until an edge sees ready; valid stays up for the next one
	task push(input logic [15:0] s);
		logic ok;
		begin
			vol_sample = s;
			vol_valid  = 1'b1;
			ok = 1'b0;
			while (!ok) begin
				ok = vol_ready;
				@(posedge sys_clk);
				#2;
			end
		end
	endtask

	// Released data line shows the inverse, never a stale copy
	task idle;
		vol_valid  = 1'b0;
		vol_sample = ~vol_sample;
	endtask
endmodule

// [dv/tb_dynamic_range_compressor.sv]
// Purpose: Self-checking bench for the compressor
// Assumes: 40 MHz clock, inputs driven 2 ns after each rising edge
// Notes:   Loud steps drive the energy estimate over threshold
`timescale 1ns/1ps
`include "drc_regs.vh"

module tb_dynamic_range_compressor;
	logic        sys_clk, nrst, reg_wr, reg_rd, vol_valid, vol_ready;
	logic        hp_valid, hp_ready, comp_active, stall, rand_stall, seen_act;
	logic [7:0]  reg_page, reg_wdata, reg_rdata, applied_gain, rd, b, min_gain, max_gain;
	logic [6:0]  reg_addr;
	logic [15:0] vol_sample, hp_sample, x1, y1;
	int          mismatches, cmp_count, cycles, got, i, n0;
	logic [7:0]  coef_rst [12] = '{8'h7F, 8'hAB, 8'h80, 8'h55, 8'h7F, 8'h56,
		8'h00, 8'h11, 8'h00, 8'h11, 8'h7F, 8'hDE};

	dynamic_range_compressor i_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_page(reg_page),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .vol_sample(vol_sample), .vol_valid(vol_valid),
		.vol_ready(vol_ready), .hp_sample(hp_sample), .hp_valid(hp_valid),
		.hp_ready(hp_ready), .applied_gain(applied_gain), .comp_active(comp_active));
	playback_partner i_p (.sys_clk(sys_clk), .stall(stall), .vol_sample(vol_sample),
		.vol_valid(vol_valid), .vol_ready(vol_ready), .hp_valid(hp_valid),
		.hp_ready(hp_ready), .got(got));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Watch gain extremes and activity; cut a hang short
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (comp_active === 1'b1) seen_act <= 1'b1;
		if ($signed(applied_gain) < $signed(min_gain)) min_gain <= applied_gain;
		if ($signed(applied_gain) > $signed(max_gain)) max_gain <= applied_gain;
		if (cycles == 80000) begin
			mismatches++;
			results;
		end
	end

	// Random sink stalls while enabled
	always @(posedge sys_clk)
		if (rand_stall) stall <= #2 ($urandom_range(0, 3) == 0);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] exp_flags(input logic act);
		return {5'b00000, act, 2'b00};
	endfunction

	// One high-pass step with the default coefficients, saturated
	function automatic logic [15:0] hp_exp(input logic signed [15:0] x, x1, y1);
		longint acc;
		acc = ($signed(`RST_HP_N0) * x + $signed(`RST_HP_N1) * x1
			+ $signed(`RST_HP_D1) * y1) >>> 15;
		return (acc > 32767) ? 16'h7fff : (acc < -32768) ? 16'h8000 : 16'(acc);
	endfunction

	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, seen);
			mismatches++;
		end
	endtask

	task wr(input logic [7:0] pg, input logic [6:0] a, input logic [7:0] d);
		@(posedge sys_clk); #2;
		reg_page = pg; reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
		@(posedge sys_clk); #2;
		reg_wr = 1'b0;
	endtask

	task rdr(input logic [7:0] pg, input logic [6:0] a, output logic [7:0] d);
		@(posedge sys_clk); #2;
		reg_page = pg; reg_addr = a; reg_rd = 1'b1;
		@(posedge sys_clk); #2;
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask

	task stream(input int n, input int base);
		repeat (n) i_p.push(16'(base + $urandom_range(0, 255)));
		i_p.idle;
	endtask

	task results;
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{nrst, reg_wr, reg_rd, stall, rand_stall, seen_act} = 6'b000000;
		{reg_page, reg_addr, reg_wdata} = 23'h00_0000;
		{mismatches, cmp_count, cycles} = 96'h0;
		void'($urandom(10));
		repeat (20) @(posedge sys_clk);
		#2 nrst = 1'b1;
		rdr(`PAGE_CTRL, `OFS_CONTROL, rd); check("control_rst", rd, `RST_CONTROL);
		rdr(`PAGE_CTRL, `OFS_HOLD, rd); check("hold_rst", rd, `RST_HOLD);
		rdr(`PAGE_CTRL, `OFS_RATES, rd); check("rates_rst", rd, `RST_RATES);
		// Coefficient resets, random write and readback, then defaults again
		for (i = 0; i < 12; i++) begin
			rdr(`PAGE_COEF, 7'(`OFS_HP_N0 + i), rd); check("coef_rst", rd, coef_rst[i]);
			b = 8'($urandom);
			wr(`PAGE_COEF, 7'(`OFS_HP_N0 + i), b);
			rdr(`PAGE_COEF, 7'(`OFS_HP_N0 + i), rd); check("coef_rw", rd, b);
			wr(`PAGE_COEF, 7'(`OFS_HP_N0 + i), coef_rst[i]);
		end
		wr(`PAGE_CTRL, `OFS_FLAGS_LIVE, 8'hFF);
		rdr(`PAGE_CTRL, `OFS_FLAGS_LIVE, rd); check("live_ro", rd, exp_flags(1'b0));
		rdr(8'h05, 7'h10, rd); check("unmapped", rd, 8'h00);
		rdr(`PAGE_COEF, 7'h1a, rd); check("past_coef", rd, 8'h00);
		// Disabled: loud steps leave the gain at the volume setting
		wr(`PAGE_CTRL, `OFS_VOLUME, 8'h18);
		stream(64, -30000);
		stream(64, 29000);
		check("gain_off", applied_gain, 8'h18);
		check("active_off", comp_active, 1'b0);
		// Recommended setup, then a random moderate attack for the run
		wr(`PAGE_CTRL, `OFS_CONTROL, 8'h7F);
		wr(`PAGE_CTRL, `OFS_HOLD, 8'h00);
		wr(`PAGE_CTRL, `OFS_RATES, 8'hB6);
		rdr(`PAGE_CTRL, `OFS_CONTROL, rd); check("control", rd, 8'h7F);
		rdr(`PAGE_CTRL, `OFS_RATES, rd); check("rates", rd, 8'hB6);
		wr(`PAGE_CTRL, `OFS_RATES, {4'($urandom_range(4, 6)), 4'h0});
		rdr(`PAGE_CTRL, `OFS_FLAGS_LATCH, rd);
		seen_act = 1'b0;
		// Extremes start here, not at the reset gain of zero
		min_gain = 8'h18;
		max_gain = 8'h81;
		rand_stall = 1'b1;
		stream(600, -30000);
		stream(600, 29000);
		rdr(`PAGE_CTRL, `OFS_FLAGS_LATCH, rd); check("sticky_set", rd & 8'hF7, exp_flags(1'b1));
		check("activated", seen_act, 1'b1);
		check("attack_cut", $signed(min_gain) < $signed(8'h18), 1'b1);
		check("gain_ceiling", $signed(max_gain) <= $signed(8'h18), 1'b1);
		// Quiet: compression releases, gain climbs back, sticky clears on read
		stream(3000, 0);
		check("released", comp_active, 1'b0);
		check("decay_up", $signed(applied_gain) > $signed(min_gain), 1'b1);
		rdr(`PAGE_CTRL, `OFS_FLAGS_LATCH, rd);
		rdr(`PAGE_CTRL, `OFS_FLAGS_LATCH, rd); check("sticky_clr", rd & 8'hF7, exp_flags(1'b0));
		rdr(`PAGE_CTRL, `OFS_FLAGS_LIVE, rd); check("live", rd & 8'hF7, exp_flags(1'b0));
		// Every sample leaves once; then fill the buffer against a stalled sink
		rand_stall = 1'b0;
		@(posedge sys_clk);
		#2 stall = 1'b0;
		for (i = 0; i < 1000 && got != 4328; i++) @(posedge sys_clk);
		check("all_out", 16'(got), 16'(4328));
		#2 stall = 1'b1;
		n0 = got;
		x1 = ~vol_sample;
		y1 = hp_sample;
		i_p.push(16'h1000);
		stream(16, 1000);
		repeat (4) @(posedge sys_clk);
		check("full", vol_ready, 1'b0);
		check("hp_out", hp_sample, hp_exp(16'h1000, x1, y1));
		check("stalled", 16'(got), 16'(n0));
		#2 stall = 1'b0;
		for (i = 0; i < 300 && got != n0 + 17; i++) @(posedge sys_clk);
		check("drained", 16'(got), 16'(n0 + 17));
		check("empty", vol_ready, 1'b1);
		results;
	end
endmodule
